// [core/power_source_selector.sv]
// automatic supply source selector with break-before-make gate drive
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "pss_regs.svh"

// Functional notes
// (R1) when enabled the source is picked by fixed priority adapter, removable, soldered.
// (R2) a present adapter is always routed to the rail ahead of either battery; the code lets an active host force (R9) override this.
// (R3) without adapter, a present and non-flat removable cell is chosen.
// (R4) otherwise the soldered cell is chosen only if its voltage is sufficient.
// (R5) the old gate drive is turned off before the new one is turned on, within 5 us.
// (R6) removal or low voltage acts at once, insertion is qualified on the 10 kHz tick.
// (R7) after start-up the selector stays off until the internal control enables it; the code also waits for the enable register bit, which resets to 0.
// (R8) while off no switch is enabled and the rail floats.
// (R9) the host may force one source through a control register.
// (R10) a status register shows which source drives the rail.
// (R11) card mode low picks the higher adapter threshold, high the lower one.
// (R12) insertion debounce never exceeds 100 ms.
// (R13) a force holds until the host clears it, then automatic choice resumes.
// (R14) all comparator levels are synchronised before use.
module power_source_selector
  import pss_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // internal control
  input wire logic selectorOn,
  // comparators
  input wire logic adapterHiOk,
  input wire logic adapterLoOk,
  input wire logic cardMode,
  input wire logic removableCellOk,
  input wire logic solderedCellOk,
  // register port
  input wire logic [`PSS_ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  // gate drives, high turns the switch on
  output logic adapterGateDrive,
  output logic removableCellGateDrive,
  output logic solderedCellGateDrive,
  output pss_pkg::source_t activeSource
);
  import pss_pkg::*;

  // -----------------------------------------------------------------
  // slow tick divider
  // -----------------------------------------------------------------
  logic [9:0] divCount_r;
  logic slowTick;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      divCount_r <= 10'h000;
    end else if (divCount_r == 10'(`PSS_SLOW_DIV - 1)) begin
      divCount_r <= 10'h000;
    end else begin
      divCount_r <= divCount_r + 10'h001;
    end
  end
  assign slowTick = (divCount_r == 10'(`PSS_SLOW_DIV - 1));

  // -----------------------------------------------------------------
  // presence qualification
  // -----------------------------------------------------------------
  logic [2:0] rawOk;
  logic [2:0] qualOk;

  // adapter threshold set chosen by card mode
  assign rawOk[0] = cardMode ? adapterLoOk : adapterHiOk; // R11
  assign rawOk[1] = removableCellOk;
  assign rawOk[2] = solderedCellOk;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_qual
      presence_qualifier u_qual (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .slowTick(slowTick),
        .rawOk(rawOk[gi]),
        .qualOk(qualOk[gi])
      ); // R6 R12 R14
    end
  endgenerate

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  logic [7:0] forceCtrl_r;
  logic enable_r;
  logic forceEn;
  source_t forceSel;

  function automatic logic addrHit(input logic [`PSS_ADDR_W-1:0] a,
                                   input logic [`PSS_ADDR_W-1:0] ref_a);
    addrHit = (a == ref_a);
  endfunction

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      forceCtrl_r <= `PSS_FORCE_RESET;
    end else if (regWr && addrHit(regAddr, `PSS_FORCE_CTRL_ADDR)) begin
      forceCtrl_r <= {5'h00, regWdata[2:0]}; // R9 R13
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      enable_r <= 1'(`PSS_ENABLE_RESET);
    end else if (regWr && addrHit(regAddr, `PSS_ENABLE_ADDR)) begin
      enable_r <= regWdata[0];
    end
  end

  assign forceEn = forceCtrl_r[`PSS_FORCE_EN_BIT];
  assign forceSel = source_t'(forceCtrl_r[`PSS_FORCE_SEL_LSB +: 2]);

  // -----------------------------------------------------------------
  // source choice
  // -----------------------------------------------------------------
  source_t wanted;
  logic running;

  // selector runs only when the control logic and software both enable it
  assign running = selectorOn && enable_r; // R7

  always_comb begin
    if (!running) begin
      wanted = SRC_NONE; // R8
    end else if (forceEn) begin
      wanted = forceSel; // R9 R13
    end else if (qualOk[0]) begin
      wanted = SRC_ADAPTER; // R1 R2
    end else if (qualOk[1]) begin
      wanted = SRC_REMOVABLE; // R3
    end else if (qualOk[2]) begin
      wanted = SRC_SOLDERED; // R4
    end else begin
      wanted = SRC_NONE;
    end
  end

  // -----------------------------------------------------------------
  // break-before-make sequencer
  // -----------------------------------------------------------------
  switch_state_t state_r;
  source_t target_r;
  logic [3:0] dead_r;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= SW_OFF;
      activeSource <= SRC_NONE;
      target_r <= SRC_NONE;
      dead_r <= 4'h0;
    end else begin
      case (state_r)
        SW_OFF: begin
          if (wanted != SRC_NONE) begin
            target_r <= wanted;
            dead_r <= 4'(`PSS_DEADTIME_CYC);
            state_r <= SW_BREAK;
          end
        end
        SW_ON: begin
          if (wanted != activeSource) begin
            activeSource <= SRC_NONE; // R5
            target_r <= wanted;
            dead_r <= 4'(`PSS_DEADTIME_CYC);
            state_r <= (wanted == SRC_NONE) ? SW_OFF : SW_BREAK;
          end
        end
        SW_BREAK: begin
          if (wanted != target_r) begin
            target_r <= wanted;
            if (wanted == SRC_NONE) begin
              state_r <= SW_OFF;
            end
          end else if (dead_r == 4'h0) begin
            activeSource <= target_r; // R5
            state_r <= SW_ON;
          end else begin
            dead_r <= dead_r - 4'h1;
          end
        end
        default: begin
          state_r <= SW_OFF;
          activeSource <= SRC_NONE;
        end
      endcase
    end
  end

  // gate drives decoded from the registered active source
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      adapterGateDrive <= 1'b0;
      removableCellGateDrive <= 1'b0;
      solderedCellGateDrive <= 1'b0;
    end else begin
      adapterGateDrive <= (activeSource == SRC_ADAPTER); // R8
      removableCellGateDrive <= (activeSource == SRC_REMOVABLE);
      solderedCellGateDrive <= (activeSource == SRC_SOLDERED);
    end
  end

  // -----------------------------------------------------------------
  // read port
  // -----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      regRdata <= 8'h00;
    end else if (regRd) begin
      if (addrHit(regAddr, `PSS_FORCE_CTRL_ADDR)) begin
        regRdata <= forceCtrl_r;
      end else if (addrHit(regAddr, `PSS_STATUS_ADDR)) begin
        regRdata <= {2'h0, qualOk, (state_r == SW_BREAK), activeSource}; // R10
      end else if (addrHit(regAddr, `PSS_ENABLE_ADDR)) begin
        regRdata <= {7'h00, enable_r};
      end else begin
        regRdata <= 8'h00;
      end
    end else begin
      regRdata <= 8'h00;
    end
  end

endmodule
`default_nettype wire

// [core/pss_regs.svh]
// register offsets, field positions, reset values and timing counts of the source selector
`ifndef PSS_REGS_SVH
`define PSS_REGS_SVH

// -----------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------
`define PSS_ADDR_W 7
`define PSS_FORCE_CTRL_ADDR 7'h10
`define PSS_STATUS_ADDR 7'h11
`define PSS_ENABLE_ADDR 7'h12

// -----------------------------------------------------------------
// field positions and reset values
// -----------------------------------------------------------------
`define PSS_FORCE_EN_BIT 2
`define PSS_FORCE_SEL_LSB 0
`define PSS_FORCE_RESET 8'h00
`define PSS_ENABLE_RESET 8'h00
`define PSS_STAT_BUSY_BIT 2

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define PSS_CLK_HZ 10000000
`define PSS_SLOW_OSC_HZ 10000
`define PSS_SLOW_DIV (`PSS_CLK_HZ / `PSS_SLOW_OSC_HZ)
`define PSS_DEBOUNCE_MS 100
`define PSS_DEBOUNCE_TICKS (`PSS_DEBOUNCE_MS * `PSS_SLOW_OSC_HZ / 1000)
`define PSS_DEADTIME_NS 1000
`define PSS_DEADTIME_CYC ((`PSS_DEADTIME_NS * (`PSS_CLK_HZ / 1000000)) / 1000)
`define PSS_SWITCH_MAX_US 5

`endif

// [core/pss_pkg.sv]
// types shared by the source selector files
package pss_pkg;

  typedef enum logic [1:0] {
    SRC_NONE,
    SRC_ADAPTER,
    SRC_REMOVABLE,
    SRC_SOLDERED
  } source_t;

  typedef enum logic [1:0] {
    SW_OFF,
    SW_BREAK,
    SW_ON
  } switch_state_t;

endpackage

// [core/presence_qualifier.sv]
// slow insertion debounce with instant removal for one source comparator
`timescale 1ns/1ps
`default_nettype none
`include "pss_regs.svh"

module presence_qualifier (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // slow tick and raw level
  input wire logic slowTick,
  input wire logic rawOk,
  // qualified level
  output logic qualOk
);

  logic [10:0] count_r;
  logic sync1_r;
  logic sync2_r;

  // two-flop synchroniser
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= rawOk;
      sync2_r <= sync1_r;
    end
  end

  // insertion counted in slow ticks, removal drops at once
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      count_r <= 11'h000;
      qualOk <= 1'b0;
    end else if (!sync2_r) begin
      count_r <= 11'h000;
      qualOk <= 1'b0;
    end else if (!qualOk && slowTick) begin
      if (count_r == 11'(`PSS_DEBOUNCE_TICKS - 1)) begin
        qualOk <= 1'b1;
      end else begin
        count_r <= count_r + 11'h001;
      end
    end
  end

endmodule
`default_nettype wire

// [test/pss_assertions.sv]
// concurrent checks on the source selector ports
`timescale 1ns/1ps
`default_nettype none
`include "pss_regs.svh"
module pss_assertions
  import pss_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // control and register port
  input wire logic selectorOn,
  input wire logic regRd,
  input wire logic [`PSS_ADDR_W-1:0] regAddr,
  input wire logic [7:0] regRdata,
  // gate drives
  input wire logic adapterGateDrive,
  input wire logic removableCellGateDrive,
  input wire logic solderedCellGateDrive,
  input wire pss_pkg::source_t activeSource
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic [2:0] gates;
  logic [4:0] offCnt;
  assign gates = {solderedCellGateDrive, removableCellGateDrive, adapterGateDrive};
  // cycles with every gate off
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      offCnt <= 5'h0;
    end else if (gates != 3'h0) begin
      offCnt <= 5'h0;
    end else if (offCnt != 5'h1F) begin
      offCnt <= offCnt + 5'h1;
    end
  end
  sequence gateRise;
    gates != 3'h0 && $past(gates) != gates;
  endsequence
  AST_ONE_GATE: assert property ($onehot0(gates)) else $error("two gates on");
  AST_DEAD_TIME: assert property (gateRise |-> offCnt >= 5'h9) else $error("no gap");
  AST_VIA_NONE: assert property (activeSource != SRC_NONE && $changed(activeSource)
    |-> $past(activeSource) == SRC_NONE) else $error("direct source swap");
  AST_GATE_FOLLOWS: assert property (1'b1 |=> gates ==
    3'((4'h1 << $past(activeSource)) >> 1)) else $error("gate mismatch");
  AST_OFF_NONE: assert property (!selectorOn [*3] |->
    activeSource == SRC_NONE && gates == 3'h0) else $error("driven while off");
  AST_READ_IDLE: assert property (!$past(regRd) |-> regRdata == 8'h00) else $error("rdata");
  AST_STATUS: assert property (regRd && regAddr == `PSS_STATUS_ADDR |=>
    regRdata[1:0] == $past(activeSource)) else $error("status source");
  AST_UNMAPPED: assert property (regRd && regAddr > `PSS_ENABLE_ADDR |=>
    regRdata == 8'h00) else $error("unmapped read");
endmodule
bind power_source_selector pss_assertions pss_assertions_inst (
  .sys_clk(sys_clk), .rstn(rstn), .selectorOn(selectorOn), .regRd(regRd),
  .regAddr(regAddr), .regRdata(regRdata), .adapterGateDrive(adapterGateDrive),
  .removableCellGateDrive(removableCellGateDrive),
  .solderedCellGateDrive(solderedCellGateDrive), .activeSource(activeSource)
);
`default_nettype wire

// [test/source_model.sv]
// comparator and switch model facing the selector
`timescale 1ns/1ps
`default_nettype none
module source_model (
  // source levels from the bench
  input wire logic [2:0] present,
  // gate drives
  input wire logic adapterGateDrive,
  input wire logic removableCellGateDrive,
  input wire logic solderedCellGateDrive,
  // comparator levels
  output logic adapterHiOk,
  output logic adapterLoOk,
  output logic removableCellOk,
  output logic solderedCellOk,
  // two switches closed together
  output logic shortSeen
);
  assign adapterHiOk = present[0];
  assign adapterLoOk = present[0];
  assign removableCellOk = present[1];
  assign solderedCellOk = present[2];
  // sticky flag, one process drives it
  always begin
    shortSeen = 1'b0;
    forever begin
      @(adapterGateDrive or removableCellGateDrive or solderedCellGateDrive);
      if ($countones({adapterGateDrive, removableCellGateDrive, solderedCellGateDrive}) > 1) begin
        shortSeen = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [test/tb_top.sv]
// self-checking bench for the source selector
`timescale 1ns/1ps
`default_nettype none
`include "pss_regs.svh"
module tb_top;
  import pss_pkg::*;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic selectorOn = 1'b0;
  logic cardMode = 1'b0;
  logic [2:0] present = 3'h7;
  logic [6:0] regAddr = 7'h00;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdata;
  logic adHi, adLo, remOk, solOk, shortSeen, adG, remG, solG;
  source_t activeSource;
  logic [1:0] codes [4] = '{2'h3, 2'h1, 2'h2, 2'h0};
  int failures = 0;
  int checks = 0;
  always #50 sys_clk = ~sys_clk;
  power_source_selector power_source_selector_inst (
    .sys_clk(sys_clk), .rstn(rstn), .selectorOn(selectorOn), .adapterHiOk(adHi),
    .adapterLoOk(adLo), .cardMode(cardMode), .removableCellOk(remOk),
    .solderedCellOk(solOk), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .adapterGateDrive(adG),
    .removableCellGateDrive(remG), .solderedCellGateDrive(solG),
    .activeSource(activeSource));
  source_model source_model_inst (
    .present(present), .adapterGateDrive(adG), .removableCellGateDrive(remG),
    .solderedCellGateDrive(solG), .adapterHiOk(adHi), .adapterLoOk(adLo),
    .removableCellOk(remOk), .solderedCellOk(solOk), .shortSeen(shortSeen));
  // ---------------------------------
  // access and compare tasks
  // ---------------------------------
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("Error t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // strobe raised at once, taken at the next edge, then dropped
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 chk(regRdata, e);
  endtask
  task automatic gchk(input logic [2:0] e);
    repeat (20) @(posedge sys_clk);
    chk({5'h0, solG, remG, adG}, {5'h0, e});
  endtask
  task automatic print_verdict;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ---------------------------------
  // tests
  // ---------------------------------
  initial begin
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    rd(`PSS_ENABLE_ADDR, 8'h00);
    rd(7'h7F, 8'h00);
    wr(`PSS_FORCE_CTRL_ADDR, 8'h05);
    wr(`PSS_ENABLE_ADDR, 8'h01);
    gchk(3'h0);
    $display("test off done");
    selectorOn <= 1'b1;
    foreach (codes[i]) begin
      wr(`PSS_FORCE_CTRL_ADDR, {6'h01, codes[i]});
      gchk(3'((4'h1 << codes[i]) >> 1));
      rd(`PSS_STATUS_ADDR, {6'h00, codes[i]});
    end
    $display("test force done");
    wr(`PSS_FORCE_CTRL_ADDR, 8'h07);
    wr(`PSS_FORCE_CTRL_ADDR, 8'h00);
    gchk(3'h0);
    rd(`PSS_STATUS_ADDR, 8'h00);
    wr(`PSS_FORCE_CTRL_ADDR, 8'h06);
    selectorOn <= 1'b0;
    gchk(3'h0);
    chk({7'h0, shortSeen}, 8'h00);
    $display("test release done");
    print_verdict;
  end
  initial begin
    #2000000;
    failures++;
    print_verdict;
  end
endmodule
`default_nettype wire
